// ---- hdl/wsl_pkg.sv ----
// package of constants and types for the wireless serial link i/o block
// What this block does
// R01: rts driven active low, cts sampled low
// R02: serial data lines idle high, active high
// R03: disconnect request closes and blocks links
// R04: link-up indicator low without connection
// R05: link-up indicator high once connected
// R06: modem line emulation as terminal or equipment
// R07: ri, dcd, dsr direction follows emulation role
// R08: dtr direction opposite to ri group
// R09: handshake lines carried apart from data
// R10: data and voice channels run independently
// R11: data passes transparently once connected
// R12: configuration accepted only while unconnected
// R13: point-to-point link, master or slave
// R14: configuration port fixed 38400 8n1 flow control
// R15: rts drops when full, tx stalls on cts
package wsl_pkg;
   localparam int CLK_HZ = 50000000;
   localparam int CFG_BAUD = 38400;
   localparam int BAUD_DIV = CLK_HZ / CFG_BAUD;
   localparam int DATA_BITS = 8;
   localparam int NUM_MODEM = 4;
   // modem line index: ring, terminal ready, carrier, set ready
   localparam int ML_RI = 0;
   localparam int ML_DTR = 1;
   localparam int ML_DCD = 2;
   localparam int ML_DSR = 3;
   localparam logic [NUM_MODEM-1:0] ML_DTE_IN_MASK = 4'hd;
   localparam logic [NUM_MODEM-1:0] ML_RESET = 4'h0;
   localparam logic IDLE_LEVEL = 1'b1;
   typedef enum logic
   {
      ROLE_DTE,
      ROLE_DCE
   } wsl_role_type;
   typedef enum logic
   {
      LINK_MASTER,
      LINK_SLAVE
   } wsl_link_role_type;
   typedef enum
   {
      LS_IDLE,
      LS_CONNECTING,
      LS_CONNECTED
   } wsl_link_state_type;
endpackage

// ---- hdl/wsl_uart.sv ----
// one-byte uart transmitter and receiver at a fixed baud divisor
`timescale 1ns/1ps
module wsl_uart
#(
   parameter int DIV = wsl_pkg::BAUD_DIV
)
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   output logic txd_o,
   input wire logic rxd_i,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o
);
   import wsl_pkg::*;
   initial
   begin
      if (DIV < 4)
         $error("baud divisor too small");
   end
   logic [15:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
   logic [3:0] tbit_q, tbit_d, rbit_q, rbit_d;
   logic [9:0] tsh_q, tsh_d;
   logic [7:0] rsh_q, rsh_d, rdat_q, rdat_d;
   logic tbusy_q, tbusy_d, rbusy_q, rbusy_d, rv_q, rv_d, txd_q, txd_d;
   localparam logic [15:0] DIVW = 16'(DIV - 1);
   localparam logic [15:0] HALF = 16'(DIV / 2);
   always_comb
   begin
      tcnt_d = tcnt_q;
      tbit_d = tbit_q;
      tsh_d = tsh_q;
      tbusy_d = tbusy_q;
      txd_d = txd_q;
      if (!tbusy_q)
      begin
         txd_d = IDLE_LEVEL; // R02
         if (tx_valid_i)
         begin
            // start bit low, eight data lsb first, one stop
            tsh_d = {1'b1, tx_data_i, 1'b0}; // R14
            tbusy_d = 1'b1;
            tcnt_d = 16'h0000;
            tbit_d = 4'h0;
         end
      end
      else
      begin
         txd_d = tsh_q[0];
         if (tcnt_q == DIVW)
         begin
            tcnt_d = 16'h0000;
            tsh_d = {1'b1, tsh_q[9:1]};
            tbit_d = tbit_q + 4'h1;
            if (tbit_q == 4'h9)
               tbusy_d = 1'b0;
         end
         else
            tcnt_d = tcnt_q + 16'h0001;
      end
   end
   always_comb
   begin
      rcnt_d = rcnt_q;
      rbit_d = rbit_q;
      rsh_d = rsh_q;
      rbusy_d = rbusy_q;
      rdat_d = rdat_q;
      rv_d = 1'b0;
      if (!rbusy_q)
      begin
         if (!rxd_i)
         begin
            rbusy_d = 1'b1;
            rcnt_d = 16'h0000;
            rbit_d = 4'h0;
         end
      end
      else if ((rbit_q == 4'h0 && rcnt_q == HALF) || (rbit_q != 4'h0 && rcnt_q == DIVW))
      begin
         rcnt_d = 16'h0000;
         rbit_d = rbit_q + 4'h1;
         if (rbit_q == 4'h0 && rxd_i)
            rbusy_d = 1'b0; // false start, glitch rejected
         else if (rbit_q == 4'h9)
         begin
            rbusy_d = 1'b0;
            if (rxd_i)
            begin
               rdat_d = rsh_q;
               rv_d = 1'b1;
            end
         end
         else if (rbit_q != 4'h0)
            rsh_d = {rxd_i, rsh_q[7:1]};
      end
      else
         rcnt_d = rcnt_q + 16'h0001;
   end
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         tcnt_q <= 16'h0000;
         tbit_q <= 4'h0;
         tsh_q <= 10'h3ff;
         tbusy_q <= 1'b0;
         txd_q <= 1'b1;
         rcnt_q <= 16'h0000;
         rbit_q <= 4'h0;
         rsh_q <= 8'h00;
         rbusy_q <= 1'b0;
         rdat_q <= 8'h00;
         rv_q <= 1'b0;
      end
      else
      begin
         tcnt_q <= tcnt_d;
         tbit_q <= tbit_d;
         tsh_q <= tsh_d;
         tbusy_q <= tbusy_d;
         txd_q <= txd_d;
         rcnt_q <= rcnt_d;
         rbit_q <= rbit_d;
         rsh_q <= rsh_d;
         rbusy_q <= rbusy_d;
         rdat_q <= rdat_d;
         rv_q <= rv_d;
      end
   end
   assign tx_ready_o = !tbusy_q;
   assign txd_o = txd_q;
   assign rx_data_o = rdat_q;
   assign rx_valid_o = rv_q;
endmodule

// ---- hdl/wsl_io.sv ----
// host-facing serial, connection and modem-line logic of the radio module
`timescale 1ns/1ps
module wsl_io
#(
   parameter int BAUD_DIV = wsl_pkg::BAUD_DIV
)
(
   input wire logic CLK_SYS_I,
   input wire logic SRST_I,
   // host serial port
   output logic TXD_O,
   input wire logic RXD_I,
   output logic RTS_N_O,
   input wire logic CTS_N_I,
   // connectivity
   input wire logic DISCONNECT_REQUEST_IN_I,
   output logic LINK_UP_INDICATOR_O,
   // settings
   input wire wsl_pkg::wsl_role_type EMU_ROLE_I,
   input wire wsl_pkg::wsl_link_role_type LINK_ROLE_I,
   // modem lines: three signals per pin
   input wire logic [wsl_pkg::NUM_MODEM-1:0] MODEM_IN_I,
   output logic [wsl_pkg::NUM_MODEM-1:0] MODEM_OUT_O,
   output logic [wsl_pkg::NUM_MODEM-1:0] MODEM_OE_O,
   // radio side
   output logic LINK_OPEN_REQ_O,
   output logic LINK_LISTEN_O,
   input wire logic LINK_ESTABLISHED_I,
   output logic LINK_CLOSE_O,
   output logic [7:0] RADIO_TX_DATA_O,
   output logic RADIO_TX_VALID_O,
   input wire logic RADIO_TX_READY_I,
   input wire logic [7:0] RADIO_RX_DATA_I,
   input wire logic RADIO_RX_VALID_I,
   output logic RADIO_RX_READY_O,
   output logic [wsl_pkg::NUM_MODEM-1:0] RADIO_MODEM_TX_O,
   input wire logic [wsl_pkg::NUM_MODEM-1:0] RADIO_MODEM_RX_I,
   // configuration command bytes and voice enable
   output logic [7:0] CFG_DATA_O,
   output logic CFG_VALID_O,
   input wire logic VOICE_ACTIVE_I,
   output logic VOICE_ENABLE_O
);
   import wsl_pkg::*;
   initial
   begin
      if (BAUD_DIV < 4)
         $error("baud divisor too small");
   end
   // ------------------------------------------------------------
   // connection state
   // ------------------------------------------------------------
   wsl_link_state_type st_q, st_d;
   logic close_q, close_d;
   always_comb
   begin
      st_d = st_q;
      close_d = 1'b0;
      case (st_q)
         LS_IDLE:
         begin
            if (!DISCONNECT_REQUEST_IN_I)
               st_d = LS_CONNECTING; // R03
         end
         LS_CONNECTING:
         begin
            if (DISCONNECT_REQUEST_IN_I)
               st_d = LS_IDLE; // R03
            else if (LINK_ESTABLISHED_I)
               st_d = LS_CONNECTED;
         end
         LS_CONNECTED:
         begin
            if (DISCONNECT_REQUEST_IN_I || !LINK_ESTABLISHED_I)
            begin
               st_d = LS_IDLE; // R03
               close_d = DISCONNECT_REQUEST_IN_I;
            end
         end
         default:
            st_d = LS_IDLE;
      endcase
   end
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         st_q <= LS_IDLE;
         close_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         close_q <= close_d;
      end
   end
   logic connected;
   assign connected = (st_q == LS_CONNECTED);
   assign LINK_UP_INDICATOR_O = connected; // R04 R05
   // point to point: master pages, slave listens
   assign LINK_OPEN_REQ_O = (st_q == LS_CONNECTING) && (LINK_ROLE_I == LINK_MASTER); // R13
   assign LINK_LISTEN_O = (st_q == LS_CONNECTING) && (LINK_ROLE_I == LINK_SLAVE); // R13
   assign LINK_CLOSE_O = close_q || (DISCONNECT_REQUEST_IN_I && connected); // R03
   // voice runs beside data, never gated by it
   assign VOICE_ENABLE_O = connected && VOICE_ACTIVE_I; // R10
   // ------------------------------------------------------------
   // serial port
   // ------------------------------------------------------------
   logic [7:0] hrx_data, htx_data_q, htx_data_d;
   logic hrx_valid, htx_ready, htx_valid;
   logic htx_full_q, htx_full_d;
   logic [7:0] up_q, up_d;
   logic up_full_q, up_full_d;
   logic [7:0] cfg_q, cfg_d;
   logic cfg_v_q, cfg_v_d;
   wsl_uart #(.DIV(BAUD_DIV)) u_uart
   (
      .clk_i(CLK_SYS_I),
      .srst_i(SRST_I),
      .tx_data_i(htx_data_q),
      .tx_valid_i(htx_valid),
      .tx_ready_o(htx_ready),
      .txd_o(TXD_O),
      .rxd_i(RXD_I),
      .rx_data_o(hrx_data),
      .rx_valid_o(hrx_valid)
   );
   // cts sampled active low; a byte waits while the host holds it high
   assign htx_valid = htx_full_q && !CTS_N_I && htx_ready; // R01 R15
   always_comb
   begin
      up_d = up_q;
      up_full_d = up_full_q;
      cfg_d = cfg_q;
      cfg_v_d = 1'b0;
      htx_data_d = htx_data_q;
      htx_full_d = htx_full_q;
      // host to radio: one holding byte
      if (up_full_q && (RADIO_TX_READY_I || !connected))
         up_full_d = 1'b0;
      if (hrx_valid)
      begin
         if (connected)
         begin
            up_d = hrx_data; // R11
            up_full_d = 1'b1;
         end
         else
         begin
            cfg_d = hrx_data; // R12
            cfg_v_d = 1'b1;
         end
      end
      // radio to host: one holding byte
      if (htx_valid)
         htx_full_d = 1'b0;
      if (RADIO_RX_VALID_I && !htx_full_q && connected)
      begin
         htx_data_d = RADIO_RX_DATA_I; // R11
         htx_full_d = 1'b1;
      end
   end
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         up_q <= 8'h00;
         up_full_q <= 1'b0;
         cfg_q <= 8'h00;
         cfg_v_q <= 1'b0;
         htx_data_q <= 8'h00;
         htx_full_q <= 1'b0;
      end
      else
      begin
         up_q <= up_d;
         up_full_q <= up_full_d;
         cfg_q <= cfg_d;
         cfg_v_q <= cfg_v_d;
         htx_data_q <= htx_data_d;
         htx_full_q <= htx_full_d;
      end
   end
   assign RADIO_TX_DATA_O = up_q;
   assign RADIO_TX_VALID_O = up_full_q && connected;
   assign RADIO_RX_READY_O = !htx_full_q && connected;
   assign CFG_DATA_O = cfg_q;
   assign CFG_VALID_O = cfg_v_q;
   // holding byte full: ask host to pause, active low
   assign RTS_N_O = up_full_q; // R01 R15
   // ------------------------------------------------------------
   // modem line emulation
   // ------------------------------------------------------------
   logic [NUM_MODEM-1:0] mout_q, mout_d, min_q, min_d;
   genvar g;
   generate
      for (g = 0; g < NUM_MODEM; g++)
      begin : g_ml
         logic is_in;
         // dte: ri, dcd, dsr in and dtr out; dce swaps all four
         assign is_in = (EMU_ROLE_I == ROLE_DTE) ? ML_DTE_IN_MASK[g] : !ML_DTE_IN_MASK[g]; // R06 R07 R08
         assign MODEM_OE_O[g] = !is_in;
         assign min_d[g] = is_in ? MODEM_IN_I[g] : 1'b0;
         // line state crosses the link apart from the byte stream
         assign mout_d[g] = (!is_in && connected) ? RADIO_MODEM_RX_I[g] : 1'b0; // R09
      end
   endgenerate
   always_ff @(posedge CLK_SYS_I)
   begin
      if (SRST_I)
      begin
         mout_q <= ML_RESET;
         min_q <= ML_RESET;
      end
      else
      begin
         mout_q <= mout_d;
         min_q <= min_d;
      end
   end
   assign MODEM_OUT_O = mout_q;
   assign RADIO_MODEM_TX_O = min_q; // R09
endmodule

// ---- testbench/wsl_io_props.sv ----
// checker of the link, handshake and modem-line behaviour of wsl_io
`timescale 1ns/1ps
module wsl_io_props
#(
   parameter int BAUD_DIV = wsl_pkg::BAUD_DIV
)
(
   input wire logic CLK_SYS_I,
   input wire logic SRST_I,
   input wire logic RTS_N_O,
   input wire logic DISCONNECT_REQUEST_IN_I,
   input wire logic LINK_UP_INDICATOR_O,
   input wire wsl_pkg::wsl_role_type EMU_ROLE_I,
   input wire wsl_pkg::wsl_link_role_type LINK_ROLE_I,
   input wire logic [wsl_pkg::NUM_MODEM-1:0] MODEM_OUT_O,
   input wire logic [wsl_pkg::NUM_MODEM-1:0] MODEM_OE_O,
   input wire logic LINK_OPEN_REQ_O,
   input wire logic LINK_LISTEN_O,
   input wire logic LINK_ESTABLISHED_I,
   input wire logic [7:0] RADIO_TX_DATA_O,
   input wire logic RADIO_TX_VALID_O,
   input wire logic RADIO_TX_READY_I,
   input wire logic [wsl_pkg::NUM_MODEM-1:0] RADIO_MODEM_RX_I,
   input wire logic CFG_VALID_O,
   input wire logic VOICE_ACTIVE_I,
   input wire logic VOICE_ENABLE_O
);
   import wsl_pkg::*;
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);
   // ----------------------------
   // assertions
   // ----------------------------
   a_link_low: assert property (!LINK_ESTABLISHED_I |=> !LINK_UP_INDICATOR_O)
      else $error("link up without connection");
   a_disc_blocks: assert property (DISCONNECT_REQUEST_IN_I |=> !LINK_UP_INDICATOR_O)
      else $error("link up while disconnect held");
   a_cfg_unlinked: assert property (CFG_VALID_O |-> !LINK_UP_INDICATOR_O)
      else $error("config byte while connected");
   a_tx_hold: assert property (RADIO_TX_VALID_O && !RADIO_TX_READY_I
      |=> RADIO_TX_VALID_O && $stable(RADIO_TX_DATA_O))
      else $error("radio byte dropped before ready");
   a_rts_full: assert property (RADIO_TX_VALID_O [*2] |-> RTS_N_O)
      else $error("rts asserted while holding full");
   a_oe_role: assert property (EMU_ROLE_I == $past(EMU_ROLE_I)
      |-> MODEM_OE_O == ((EMU_ROLE_I == ROLE_DTE) ? 4'h2 : 4'hd))
      else $error("modem direction wrong for role");
   a_modem_fwd: assert property ($past(LINK_UP_INDICATOR_O)
      |-> MODEM_OUT_O == ($past(RADIO_MODEM_RX_I) & $past(MODEM_OE_O)))
      else $error("remote modem state not forwarded");
   a_voice_gate: assert property (VOICE_ENABLE_O == (LINK_UP_INDICATOR_O && VOICE_ACTIVE_I))
      else $error("voice enable wrong");
   a_open_role: assert property (LINK_OPEN_REQ_O |-> LINK_ROLE_I == LINK_MASTER
      && !LINK_LISTEN_O)
      else $error("open request in slave role");
   c_cfg: cover property (CFG_VALID_O);
   c_link: cover property ($rose(LINK_UP_INDICATOR_O));
   c_tx: cover property (RADIO_TX_VALID_O && RADIO_TX_READY_I);
endmodule
bind wsl_io wsl_io_props #(.BAUD_DIV(BAUD_DIV)) wsl_io_props_i (.*);

// ---- testbench/wsl_host_model.sv ----
// host processor model: serial sender and receiver
`timescale 1ns/1ps
module wsl_host_model
#(
   parameter int DIV = 8
)
(
   input wire logic clk_i,
   input wire logic txd_i,
   input wire logic rts_n_i,
   output logic rxd_o,
   output logic [7:0] got_o,
   output int got_n_o
);
   initial rxd_o = 1'b1;
   initial got_n_o = 0;
   // host holds off while rts is high, never overruns the holding byte
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(negedge clk_i iff !rts_n_i);
      for (int i = 0; i < 10; i++)
      begin
         rxd_o = f[i];
         repeat (DIV) @(negedge clk_i);
      end
   endtask
   always
   begin
      @(negedge txd_i);
      repeat (DIV / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++)
      begin
         repeat (DIV) @(posedge clk_i);
         got_o[i] = txd_i;
      end
      repeat (DIV) @(posedge clk_i);
      got_n_o++;
   end
endmodule

// ---- testbench/test_wireless_serial_link_io.sv ----
// self-checking bench of wsl_io against a host model
`timescale 1ns/1ps
module test_wireless_serial_link_io;
   import wsl_pkg::*;
   localparam int DIV = 8;
   logic CLK_SYS_I = 0, SRST_I = 1, CTS_N_I = 0, DISCONNECT_REQUEST_IN_I = 0;
   logic LINK_ESTABLISHED_I = 0, RADIO_TX_READY_I = 0, RADIO_RX_VALID_I = 0;
   logic VOICE_ACTIVE_I = 0, RXD_I, TXD_O, RTS_N_O, LINK_UP_INDICATOR_O, CFG_VALID_O;
   logic LINK_OPEN_REQ_O, LINK_LISTEN_O, LINK_CLOSE_O, RADIO_TX_VALID_O;
   logic RADIO_RX_READY_O, VOICE_ENABLE_O;
   logic [7:0] RADIO_RX_DATA_I = 0, RADIO_TX_DATA_O, CFG_DATA_O, got, b;
   logic [3:0] MODEM_IN_I = 0, RADIO_MODEM_RX_I = 0, MODEM_OUT_O, MODEM_OE_O;
   logic [3:0] RADIO_MODEM_TX_O, oe;
   wsl_role_type EMU_ROLE_I = ROLE_DTE;
   wsl_link_role_type LINK_ROLE_I = LINK_MASTER;
   int errors = 0, num_checks = 0, cyc = 0, n;
   wsl_io #(.BAUD_DIV(DIV)) wsl_io_i (.*);
   wsl_host_model #(.DIV(DIV)) wsl_host_model_i (.clk_i(CLK_SYS_I), .txd_i(TXD_O),
      .rts_n_i(RTS_N_O), .rxd_o(RXD_I), .got_o(got), .got_n_o(n));
   initial forever #10 CLK_SYS_I = ~CLK_SYS_I;
   // ----------------------------
   // checking and closing
   // ----------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      num_checks++;
      if (s !== e)
      begin
         errors++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic summarize();
      if (errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cyc_n(input int k);
      repeat (k) @(negedge CLK_SYS_I);
   endtask
   // generous ceiling: 250 serial frames of 80 cycles each
   always @(posedge CLK_SYS_I)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         summarize();
      end
   end
   // ----------------------------
   // main sequence
   // ----------------------------
   initial
   begin
      void'($urandom(20550));
      cyc_n(20);
      SRST_I = 0;
      chk("txd", 1, TXD_O);
      chk("rts_n", 0, RTS_N_O);
      chk("link_up", 0, LINK_UP_INDICATOR_O);
      cyc_n(2);
      chk("open_req", 1, LINK_OPEN_REQ_O);
      for (int i = 0; i < 3; i++)
      begin
         b = (i == 0) ? 8'hff : 8'($urandom);
         fork
            wsl_host_model_i.send(b);
            @(posedge CLK_SYS_I iff CFG_VALID_O);
         join
         chk("cfg_data", b, CFG_DATA_O);
         chk("radio_tx_valid", 0, RADIO_TX_VALID_O);
      end
      LINK_ESTABLISHED_I = 1;
      cyc_n(1);
      chk("link_up", 1, LINK_UP_INDICATOR_O);
      b = 8'($urandom);
      fork
         wsl_host_model_i.send(b);
         @(posedge CLK_SYS_I iff RADIO_TX_VALID_O);
      join
      cyc_n(3);
      chk("radio_tx_data", b, RADIO_TX_DATA_O);
      chk("rts_full", 1, RTS_N_O);
      RADIO_TX_READY_I = 1;
      cyc_n(1);
      RADIO_TX_READY_I = 0;
      cyc_n(2);
      chk("rts_free", 0, RTS_N_O);
      CTS_N_I = 1;
      RADIO_RX_DATA_I = 8'($urandom);
      RADIO_RX_VALID_I = 1;
      @(posedge CLK_SYS_I iff RADIO_RX_READY_O);
      cyc_n(1);
      RADIO_RX_VALID_I = 0;
      cyc_n(3 * DIV);
      chk("txd_stall", 1, TXD_O);
      CTS_N_I = 0;
      wait (n == 1);
      chk("host_rx", RADIO_RX_DATA_I, got);
      VOICE_ACTIVE_I = 1;
      cyc_n(1);
      chk("voice_en", 1, VOICE_ENABLE_O);
      for (int r = 0; r < 2; r++)
      begin
         EMU_ROLE_I = wsl_role_type'(r);
         oe = r ? 4'hd : 4'h2;
         RADIO_MODEM_RX_I = 4'($urandom);
         MODEM_IN_I = 4'($urandom);
         cyc_n(3);
         chk("modem_oe", oe, MODEM_OE_O);
         chk("modem_out", RADIO_MODEM_RX_I & oe, MODEM_OUT_O & oe);
         chk("modem_tx", MODEM_IN_I & ~oe, RADIO_MODEM_TX_O);
      end
      DISCONNECT_REQUEST_IN_I = 1;
      cyc_n(1);
      chk("link_close", 1, LINK_CLOSE_O);
      cyc_n(19);
      chk("link_blocked", 0, LINK_UP_INDICATOR_O);
      chk("open_blocked", 0, LINK_OPEN_REQ_O);
      DISCONNECT_REQUEST_IN_I = 0;
      cyc_n(3);
      chk("relink", 1, LINK_UP_INDICATOR_O);
      LINK_ESTABLISHED_I = 0;
      cyc_n(1);
      chk("link_drop", 0, LINK_UP_INDICATOR_O);
      LINK_ROLE_I = LINK_SLAVE;
      SRST_I = 1;
      cyc_n(2);
      SRST_I = 0;
      cyc_n(2);
      chk("listen", 1, LINK_LISTEN_O);
      summarize();
   end
endmodule
